// file: rtc_pin_control_logic.sv
// Pin control logic of a serial real-time clock: serial port, slow clock gate,
// interrupt/square pin, open-drain reset with pushbutton, oscillator-stop flag.
// Assumes register contents, alarm matching and square-wave sources live outside.
`timescale 1ns/100ps

// Contract
// - Serial port takes part only while select is low.
// - Slow clock output low when either slow clock enable bit is zero.
// - Interrupt select zero drives the chosen square wave on the shared pin.
// - Interrupt select one pulls shared pin low on an enabled alarm match.
// - At power-up interrupt select is one and both alarms are disabled.
// - Reset pin is driven low while power-fail is indicated.
// - After power returns, reset pin stays low for the recovery delay, then the reset-active interval.
// - With oscillator disabled the recovery delay is skipped.
// - With oscillator disabled the reset-active interval is bypassed too.
// - Reset pin is also sampled as a debounced pushbutton input.
// - Oscillator-stopped flag sets after the oscillator stays stopped long enough.
// - Serial clock level at select fall sets the idle polarity.
// - Address byte then write data arrive through the serial data input.
// - Serial data output is driven only during the read phase.
// - Pushbutton: falling edge, debounce low, wait release, hold reset low.
// - Below power-fail and backup, serial register access is blocked.
module rtc_pin_control_logic
  import rtc_pin_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned RESET_ACTIVE_CYCLES = RESET_ACTIVE_CYC,
  parameter int unsigned OSC_STOP_CYCLES = OSC_STOP_CYC,
  parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clock_enable_i,
  input wire logic select_n_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output reg_write_t reg_write_o,
  output logic [7:0] read_address_o,
  input wire logic [7:0] read_data_i,
  input wire control_bits_t control_i,
  input wire logic [1:0] alarm_enable_i,
  input wire logic [1:0] alarm_match_i,
  input wire logic [3:0] square_waves_i,
  input wire logic slow_clock_i,
  input wire logic power_fail_i,
  input wire logic below_backup_i,
  input wire logic oscillator_running_i,
  input wire logic osc_flag_clear_i,
  input wire logic reset_pin_i,
  output logic reset_pin_oe_o,
  output logic irq_or_square_pin_oe_o,
  output logic slow_clock_o,
  output logic oscillator_stopped_flag_o,
  output logic interrupt_select_o,
  output logic [1:0] alarm_enable_o
);

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pins from outside the clock domain pass two flops before use
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 6'h3f;
      pin_sync <= 6'h3f;
    end else if (clock_enable_i) begin
      pin_meta <= {select_n_i, serial_clock_i, serial_data_i, reset_pin_i,
                   slow_clock_i, oscillator_running_i};
      pin_sync <= pin_meta;
    end
  end
  logic sel_n;
  logic sck;
  logic sdi;
  logic rst_pin;
  logic osc_run;
  assign sel_n = pin_sync[5];
  assign sck = pin_sync[4];
  assign sdi = pin_sync[3];
  assign rst_pin = pin_sync[2];
  assign osc_run = pin_sync[0];

  logic sel_n_d;
  logic sck_d;
  logic rst_pin_d;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_d <= 1'h1;
      sck_d <= 1'h1;
      rst_pin_d <= 1'h1;
    end else if (clock_enable_i) begin
      sel_n_d <= sel_n;
      sck_d <= sck;
      rst_pin_d <= rst_pin;
    end
  end

  // ****************************************
  // Serial port
  // ****************************************
  logic idle_pol;
  logic sck_rise;
  logic sck_fall;
  logic lead_edge;
  logic trail_edge;
  logic sel_start;
  logic access_ok;
  assign sck_rise = sck & ~sck_d;
  assign sck_fall = ~sck & sck_d;
  assign sel_start = ~sel_n & sel_n_d;
  // Modes 1 and 3: shift out on the leading edge, sample on the trailing one
  assign lead_edge = idle_pol ? sck_fall : sck_rise;
  assign trail_edge = idle_pol ? sck_rise : sck_fall;
  assign access_ok = ~(power_fail_i & below_backup_i);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      idle_pol <= 1'h0;
    end else if (clock_enable_i && sel_start) begin
      idle_pol <= sck;
    end
  end

  serial_phase_t phase;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] address;
  logic [7:0] next_shift_in;
  assign next_shift_in = {shift_in[6:0], sdi};

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= SER_ADDR;
      bit_cnt <= BIT_CNT_RESET;
      shift_in <= 8'h00;
      address <= 8'h00;
      reg_write_o <= '0;
    end else if (clock_enable_i) begin
      reg_write_o.write_valid <= 1'h0;
      if (sel_n || sel_start) begin
        phase <= SER_ADDR;
        bit_cnt <= BIT_CNT_RESET;
      end else if (trail_edge) begin
        shift_in <= next_shift_in;
        bit_cnt <= bit_cnt - 3'h1;
        if (bit_cnt == 3'h0) begin
          if (phase == SER_ADDR) begin
            address <= next_shift_in;
            phase <= (next_shift_in & WRITE_FLAG_MASK) != 8'h00 ? SER_WRITE : SER_READ;
          end else begin
            // Multibyte access steps to the next address; the register side wraps
            address <= address + 8'h01;
            if (phase == SER_WRITE && access_ok) begin
              reg_write_o.write_valid <= 1'h1;
              reg_write_o.address <= address;
              reg_write_o.data <= next_shift_in;
            end
          end
        end
      end
    end
  end

  // Read data is loaded when a byte of the read phase starts
  logic read_load;
  assign read_load = (phase == SER_READ) && lead_edge && (bit_cnt == BIT_CNT_RESET);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_out <= 8'h00;
      serial_data_o <= 1'h0;
      serial_data_oe_o <= 1'h0;
      read_address_o <= 8'h00;
    end else if (clock_enable_i) begin
      read_address_o <= address;
      serial_data_oe_o <= ~sel_n & (phase == SER_READ);
      if (sel_n) begin
        serial_data_o <= 1'h0;
      end else if (read_load) begin
        shift_out <= {(access_ok ? read_data_i[6:0] : 7'h00), 1'h0};
        serial_data_o <= access_ok ? read_data_i[7] : 1'h0;
      end else if (phase == SER_READ && lead_edge) begin
        shift_out <= {shift_out[6:0], 1'h0};
        serial_data_o <= shift_out[7];
      end
    end
  end

  // ****************************************
  // Control defaults, slow clock and shared pin
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_select_o <= INTERRUPT_SELECT_RESET;
      alarm_enable_o <= {2{ALARM_ENABLE_RESET}};
      slow_clock_o <= 1'h0;
      irq_or_square_pin_oe_o <= 1'h0;
    end else if (clock_enable_i) begin
      interrupt_select_o <= control_i.interrupt_select;
      alarm_enable_o <= alarm_enable_i;
      slow_clock_o <= pin_sync[1] & control_i.slow_clock_out_enable
                      & control_i.slow_clock_backup_enable;
      if (!control_i.interrupt_select) begin
        // Open drain: low half of the square wave is driven, high is released
        irq_or_square_pin_oe_o <= ~square_waves_i[{control_i.rate_select_high,
                                                   control_i.rate_select_low}];
      end else begin
        irq_or_square_pin_oe_o <= |(alarm_match_i & alarm_enable_i);
      end
    end
  end

  // ****************************************
  // Reset pin, pushbutton and recovery
  // ****************************************
  reset_state_t rst_state;
  logic [31:0] rst_timer;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_state <= PB_IDLE;
      rst_timer <= 32'h0;
      reset_pin_oe_o <= 1'h0;
    end else if (clock_enable_i) begin
      if (power_fail_i) begin
        rst_state <= PB_RECOVER;
        rst_timer <= 32'h0;
        reset_pin_oe_o <= 1'h1;
      end else begin
        case (rst_state)
          PB_IDLE: begin
            reset_pin_oe_o <= 1'h0;
            if (!rst_pin && rst_pin_d) begin
              rst_state <= PB_DEBOUNCE;
              rst_timer <= 32'h0;
              reset_pin_oe_o <= 1'h1;
            end
          end
          PB_DEBOUNCE: begin
            rst_timer <= rst_timer + 32'h1;
            if (rst_timer >= DEBOUNCE_CYCLES - 1) begin
              rst_state <= PB_WAIT_RELEASE;
              reset_pin_oe_o <= 1'h0;
            end
          end
          PB_WAIT_RELEASE: begin
            // Our own drive has just dropped; the pin level is read two flops later
            if (rst_pin && rst_pin_d) begin
              rst_state <= PB_HOLD;
              rst_timer <= 32'h0;
              reset_pin_oe_o <= 1'h1;
            end
          end
          PB_HOLD: begin
            rst_timer <= rst_timer + 32'h1;
            if (control_i.oscillator_disable || rst_timer >= RESET_ACTIVE_CYCLES - 1) begin
              rst_state <= PB_IDLE;
              reset_pin_oe_o <= 1'h0;
            end
          end
          PB_RECOVER: begin
            rst_timer <= rst_timer + 32'h1;
            if (control_i.oscillator_disable) begin
              rst_state <= PB_IDLE;
              reset_pin_oe_o <= 1'h0;
            end else if (rst_timer >= RECOVERY_CYCLES - 1) begin
              rst_state <= PB_HOLD;
              rst_timer <= 32'h0;
            end
          end
          default: begin
            rst_state <= PB_IDLE;
            reset_pin_oe_o <= 1'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Oscillator-stop detection
  // ****************************************
  logic [31:0] stop_timer;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      stop_timer <= 32'h0;
      oscillator_stopped_flag_o <= 1'h0;
    end else if (clock_enable_i) begin
      stop_timer <= osc_run ? 32'h0
                    : stop_timer + ((stop_timer < OSC_STOP_CYCLES) ? 32'h1 : 32'h0);
      // The set wins over a clear in the same cycle
      if (!osc_run && stop_timer >= OSC_STOP_CYCLES - 1) begin
        oscillator_stopped_flag_o <= 1'h1;
      end else if (osc_flag_clear_i) begin
        oscillator_stopped_flag_o <= 1'h0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  AST_SELECT_IDLE: assert property (sel_n |=> !reg_write_o.write_valid)
    else $error("write issued while deselected");
  AST_SLOW_GATE: assert property (clock_enable_i && !(control_i.slow_clock_out_enable
    && control_i.slow_clock_backup_enable) |=> !slow_clock_o)
    else $error("slow clock not gated");
  AST_ALARM_IRQ: assert property (clock_enable_i && control_i.interrupt_select
    && |(alarm_match_i & alarm_enable_i) |=> irq_or_square_pin_oe_o)
    else $error("alarm did not pull pin");
  AST_NO_ALARM: assert property (clock_enable_i && control_i.interrupt_select
    && !(|(alarm_match_i & alarm_enable_i)) |=> !irq_or_square_pin_oe_o)
    else $error("pin pulled without alarm");
  AST_SQUARE: assert property (clock_enable_i && !control_i.interrupt_select
    |=> irq_or_square_pin_oe_o == !$past(square_waves_i[{control_i.rate_select_high,
    control_i.rate_select_low}]))
    else $error("square wave mismatch");
  AST_POWER_FAIL: assert property (clock_enable_i && power_fail_i |=> reset_pin_oe_o)
    else $error("reset pin not driven on power fail");
  AST_OSC_OFF: assert property (clock_enable_i && !power_fail_i
    && control_i.oscillator_disable && rst_state == PB_RECOVER |=> !reset_pin_oe_o)
    else $error("recovery not bypassed");
  AST_DOUT_READ: assert property (serial_data_oe_o |-> $past(phase) == SER_READ)
    else $error("output driven outside read");
  AST_RELEASE: assert property (clock_enable_i && sel_n |=> !serial_data_oe_o)
    else $error("output not released");
  AST_OSF: assert property (clock_enable_i && !osc_run && stop_timer >= OSC_STOP_CYCLES - 1
    |=> oscillator_stopped_flag_o)
    else $error("stop flag not set");

  COV_WRITE: cover property (reg_write_o.write_valid);
  COV_READ: cover property (serial_data_oe_o);
  COV_PUSH: cover property (rst_state == PB_HOLD);
  COV_OSF: cover property (oscillator_stopped_flag_o);

endmodule : rtc_pin_control_logic

// file: rtc_pin_pkg.sv
// Constants, states and carriers for the real-time clock pin control logic.
// Assumes a 10 MHz system clock; all times are converted to cycle counts here.
package rtc_pin_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned DEBOUNCE_MS = 250;
  localparam int unsigned RESET_ACTIVE_MS = 250;
  localparam int unsigned OSC_STOP_MS = 100;
  localparam int unsigned RECOVERY_MS = 125;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned RESET_ACTIVE_CYC = RESET_ACTIVE_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_STOP_CYC = OSC_STOP_MS * (CLK_HZ / 1000);
  localparam int unsigned RECOVERY_CYC = RECOVERY_MS * (CLK_HZ / 1000);

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [2:0] BIT_CNT_RESET = 3'h7;
  localparam logic [7:0] WRITE_FLAG_MASK = 8'h80;

  // ****************************************
  // Reset values of control bits
  // ****************************************
  localparam logic INTERRUPT_SELECT_RESET = 1'h1;
  localparam logic ALARM_ENABLE_RESET = 1'h0;

  typedef enum logic [2:0] {
    PB_IDLE,
    PB_DEBOUNCE,
    PB_WAIT_RELEASE,
    PB_HOLD,
    PB_RECOVER
  } reset_state_t;

  typedef enum logic [1:0] {
    SER_ADDR,
    SER_WRITE,
    SER_READ
  } serial_phase_t;

  // Register access request handed to the register file
  typedef struct packed {
    logic write_valid;
    logic [7:0] address;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic slow_clock_out_enable;
    logic slow_clock_backup_enable;
    logic interrupt_select;
    logic rate_select_high;
    logic rate_select_low;
    logic oscillator_disable;
  } control_bits_t;

endpackage : rtc_pin_pkg

// file: rtc_host_model.sv
// Serial host and pushbutton model facing the pin control logic.
// Assumes a 100 ns bench clock; one link bit spans ten bench cycles (1000 ns).
`timescale 1ns/100ps
module rtc_host_model (
  input wire logic clock_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic reset_pin_oe_o,
  output logic select_n_o,
  output logic serial_clock_o,
  output logic host_data_o,
  output logic reset_pin_o
);
  logic pressed = 1'b0;
  // A released data output reads back as the inverse of the held value
  logic dout_seen;
  assign dout_seen = serial_data_oe_o ? serial_data_o : !serial_data_o;
  initial begin
    select_n_o = 1'b1;
    serial_clock_o = 1'b0;
    host_data_o = 1'b0;
  end
  // Pin has a pull-up; either party may pull it low
  assign reset_pin_o = !(reset_pin_oe_o || pressed);
  task automatic frame(input logic desel, input logic pol, input logic [15:0] tx,
                       output logic [7:0] rx);
    rx = 8'h00;
    serial_clock_o = pol;
    @(negedge clock_i);
    select_n_o = desel;
    for (int i = 15; i >= 0; i--) begin
      repeat (2) @(negedge clock_i);
      host_data_o = tx[i];
      repeat (2) @(negedge clock_i);
      serial_clock_o = !pol;
      repeat (4) @(negedge clock_i);
      serial_clock_o = pol;
      repeat (2) @(negedge clock_i);
      // Read data stands until the next leading edge, so take it late
      if (i < 8) rx[i] = dout_seen;
    end
    select_n_o = 1'b1;
    // A released line does not keep its last value
    host_data_o = !host_data_o;
  endtask : frame
  task automatic press(input int unsigned n);
    pressed = 1'b1;
    repeat (n) @(negedge clock_i);
    pressed = 1'b0;
  endtask : press
endmodule : rtc_host_model

// file: rtc_pin_control_logic_tb.sv
// Self-checking bench for the real-time clock pin control logic.
// Assumes rtc_host_model plays the serial host and the pushbutton.
`timescale 1ns/100ps
module rtc_pin_control_logic_tb;
  import rtc_pin_pkg::*;
  localparam int unsigned N = 20;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel_n, sclk, sdi, rst_pin, sdo, sdo_oe, rst_oe, irq_oe, slow_o, oscillator_stopped_flag, isel_o;
  logic [1:0] aen_o;
  logic [7:0] raddr;
  reg_write_t wr;
  reg_write_t wr_last = '0;
  control_bits_t ctl = '0;
  logic [1:0] aen = 2'h0;
  logic [1:0] amatch = 2'h0;
  logic [3:0] sq = 4'h5;
  logic ce = 1'b1;
  logic slow_in = 1'b0, pf = 1'b0, bb = 1'b0, osc_run = 1'b1, osf_clr = 1'b0;
  int n_fail = 0, checks_done = 0, cycles = 0, wr_cnt = 0, oe_cnt = 0;

  rtc_pin_control_logic #(.DEBOUNCE_CYCLES(N), .RESET_ACTIVE_CYCLES(N),
    .OSC_STOP_CYCLES(N), .RECOVERY_CYCLES(N)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clock_enable_i(ce),
    .select_n_i(sel_n), .serial_clock_i(sclk), .serial_data_i(sdi),
    .serial_data_o(sdo), .serial_data_oe_o(sdo_oe), .reg_write_o(wr),
    .read_address_o(raddr), .read_data_i(raddr ^ 8'ha5), .control_i(ctl),
    .alarm_enable_i(aen), .alarm_match_i(amatch), .square_waves_i(sq),
    .slow_clock_i(slow_in), .power_fail_i(pf), .below_backup_i(bb),
    .oscillator_running_i(osc_run), .osc_flag_clear_i(osf_clr),
    .reset_pin_i(rst_pin), .reset_pin_oe_o(rst_oe), .irq_or_square_pin_oe_o(irq_oe),
    .slow_clock_o(slow_o), .oscillator_stopped_flag_o(oscillator_stopped_flag),
    .interrupt_select_o(isel_o), .alarm_enable_o(aen_o));

  rtc_host_model host (.clock_i(clock_i), .serial_data_o(sdo), .reset_pin_oe_o(rst_oe),
    .serial_data_oe_o(sdo_oe),
    .select_n_o(sel_n), .serial_clock_o(sclk), .host_data_o(sdi), .reset_pin_o(rst_pin));

  // ****************************************
  // Clocks and monitors
  // ****************************************
  always #50 clock_i = ~clock_i;
  always begin
    repeat (7) @(negedge clock_i);
    slow_in = ~slow_in;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (wr.write_valid === 1'b1) begin
      wr_cnt++;
      wr_last = wr;
    end
    if (sdo_oe === 1'b1) oe_cnt++;
    // Run needs about 1700 cycles; the ceiling leaves ample margin
    if (cycles == 8000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_release(output int n);
    n = 0;
    while (rst_oe === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask : wait_release
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write(input logic pol, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rx;
    int w;
    w = wr_cnt;
    oe_cnt = 0;
    host.frame(1'b0, pol, {a | 8'h80, d}, rx);
    cyc(8);
    check(16'(wr_cnt - w), 16'h1);
    check({1'b0, wr_last.address[6:0], wr_last.data}, {1'b0, a[6:0], d});
    check(16'(oe_cnt), 16'h0);
    $display("write test done");
  endtask : t_write
  task automatic t_read(input logic pol, input logic [7:0] a);
    logic [7:0] rx;
    oe_cnt = 0;
    host.frame(1'b0, pol, {a, 8'h00}, rx);
    check(16'(oe_cnt > 0), 16'h1);
    cyc(4);
    check({sdo_oe, rx}, {1'b0, a ^ 8'ha5});
    $display("read test done");
  endtask : t_read
  task automatic t_desel();
    logic [7:0] rx;
    int w;
    w = wr_cnt;
    oe_cnt = 0;
    host.frame(1'b1, 1'b0, 16'h8133, rx);
    cyc(8);
    check(16'(wr_cnt - w + oe_cnt), 16'h0);
    $display("deselect test done");
  endtask : t_desel
  task automatic t_slow();
    int hi;
    for (int e = 0; e < 4; e++) begin
      {ctl.slow_clock_out_enable, ctl.slow_clock_backup_enable} = 2'(e);
      cyc(8);
      hi = 0;
      for (int k = 0; k < 42; k++) begin
        cyc(1);
        hi += int'(slow_o === 1'b1);
      end
      check(16'(hi > 0 && hi < 42), 16'(e == 3));
    end
    $display("slow clock test done");
  endtask : t_slow
  task automatic t_square();
    ctl.interrupt_select = 1'b0;
    for (int k = 0; k < 8; k++) begin
      sq = k < 4 ? 4'h5 : 4'ha;
      {ctl.rate_select_high, ctl.rate_select_low} = 2'(k);
      cyc(6);
      check(16'(irq_oe), 16'(!sq[k % 4]));
    end
    $display("square test done");
  endtask : t_square
  task automatic t_alarm();
    // Entries are enable, match, expected pull
    logic [4:0] tbl [5] = '{5'b00110, 5'b01011, 5'b10101, 5'b01100, 5'b11101};
    ctl.interrupt_select = 1'b1;
    foreach (tbl[k]) begin
      {aen, amatch} = tbl[k][4:1];
      cyc(6);
      check(16'(irq_oe), 16'(tbl[k][0]));
    end
    {aen, amatch} = 4'h0;
    $display("alarm test done");
  endtask : t_alarm
  task automatic t_osc();
    osc_run = 1'b0;
    cyc(N / 2);
    osc_run = 1'b1;
    cyc(4);
    check(16'(oscillator_stopped_flag), 16'h0);
    // Clock enable low must freeze the stop timer and the flag
    ce = 1'b0;
    osc_run = 1'b0;
    cyc(N + 8);
    check(16'(oscillator_stopped_flag), 16'h0);
    ce = 1'b1;
    cyc(N + 8);
    osc_run = 1'b1;
    cyc(4);
    check(16'(oscillator_stopped_flag), 16'h1);
    osf_clr = 1'b1;
    cyc(1);
    osf_clr = 1'b0;
    cyc(4);
    check(16'(oscillator_stopped_flag), 16'h0);
    $display("stop flag test done");
  endtask : t_osc
  task automatic t_power(input logic od);
    int n;
    ctl.oscillator_disable = od;
    pf = 1'b1;
    cyc(4);
    check(16'(rst_oe), 16'h1);
    pf = 1'b0;
    wait_release(n);
    // Recovery then reset-active, unless the oscillator is off
    check(16'(od ? n <= 6 : n >= 2 * N && n <= 2 * N + 8), 16'h1);
    $display("power test done");
  endtask : t_power
  task automatic t_block();
    logic [7:0] rx;
    int w;
    pf = 1'b1;
    bb = 1'b1;
    w = wr_cnt;
    host.frame(1'b0, 1'b0, 16'h8266, rx);
    host.frame(1'b0, 1'b1, 16'h0200, rx);
    cyc(8);
    check({8'(wr_cnt - w), rx}, 16'h0);
    pf = 1'b0;
    bb = 1'b0;
    ctl.oscillator_disable = 1'b0;
    // Recovery and reset-active must run out before the button is pressed
    cyc(2 * N + 16);
    $display("blocked access test done");
  endtask : t_block
  task automatic t_button();
    int n;
    fork
      host.press(3 * N);
      begin
        cyc(N / 2);
        check(16'(rst_oe), 16'h1);
        cyc(2 * N);
        check(16'(rst_oe), 16'h0);
      end
    join
    cyc(4);
    check(16'(rst_oe), 16'h1);
    wait_release(n);
    check(16'(n >= N - 5 && n <= N + 4), 16'h1);
    $display("pushbutton test done");
  endtask : t_button

  initial begin
    cyc(2);
    check({isel_o, aen_o}, 16'h4);
    rst_n_i = 1'b1;
    cyc(4);
    t_write(1'b0, 8'h0e, 8'h5a);
    t_write(1'b1, 8'h07, 8'ha3);
    t_read(1'b0, 8'h0e);
    t_read(1'b1, 8'h11);
    t_desel();
    t_slow();
    t_square();
    t_alarm();
    t_osc();
    t_power(1'b0);
    t_power(1'b1);
    t_block();
    t_button();
    print_verdict();
  end
endmodule : rtc_pin_control_logic_tb
